// ==== design/ipr_params.svh ====
// constants for the interrupt presentation register block
// assumes inclusion by the package and the design module
`ifndef IPR_PARAMS_SVH
`define IPR_PARAMS_SVH
`define IPR_OFS_POLL      4'h0
`define IPR_OFS_ACK       4'h4
`define IPR_PRIO_LSB      24
`define IPR_PRIO_MSB      31
`define IPR_SRC_MSB       23
`define IPR_IMPL_MSB      10
`define IPR_BUS_UNIT_IDENTIFIER_LSB      11
`define IPR_BUS_UNIT_IDENTIFIER_MSB      19
`define IPR_NUM_LSB       20
`define IPR_SRC_NONE      24'h000000
`define IPR_SRC_EARLY_POWER_WARNING      24'h000001
`define IPR_SRC_IPI_FIRST 24'h000002
`define IPR_PRIO_LEAST    8'hff
`define IPR_PRIO_RESET    8'hff
`define IPR_ACK_WAIT      2
`endif

// ==== design/ipr_pkg.sv ====
// types for the interrupt presentation register block
// assumes ipr_params.svh on the include path
`include "ipr_params.svh"
package ipr_pkg;
  typedef enum logic [1:0] {
    IPR_IDLE  = 2'b00,
    IPR_DROP  = 2'b01,
    IPR_REPLY = 2'b11
  } ipr_state_t;

  typedef struct packed {
    ipr_state_t  state;
    logic [7:0]  prio;
    logic [23:0] src;
    logic [7:0]  src_prio;
    logic [1:0]  wait_cnt;
    logic        irq;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        eoi_valid;
    logic [23:0] eoi_src;
    logic        reject;
    logic [23:0] reject_src;
    logic        req_ready;
  } ipr_regs_t;
endpackage : ipr_pkg

// ==== design/ipr_presentation.sv ====
// per-processor interrupt request word: polling and acknowledge copies,
// priority register, interrupt line, end-of-service and rejection outputs
// assumes one access at a time from the processor port, held until RD_VALID
// for loads, and a routing layer offering its best request on REQ_*
`include "ipr_params.svh"
module ipr_presentation #(
  parameter int ACK_WAIT = `IPR_ACK_WAIT
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        ACC_REQ,
  input  wire logic        ACC_WRITE,
  input  wire logic [3:0]  ACC_ADDR,
  input  wire logic        ACC_WORD,
  input  wire logic [31:0] ACC_WDATA,
  output logic             RD_VALID,
  output logic [31:0]      RD_DATA,
  input  wire logic        REQ_VALID,
  input  wire logic [23:0] REQ_SRC,
  input  wire logic [7:0]  REQ_PRIO,
  input  wire logic [7:0]  QUEUED_PRIO,
  output logic             REQ_READY,
  output logic             IRQ,
  output logic             EOI_VALID,
  output logic [23:0]      EOI_SRC,
  output logic             REJECT_VALID,
  output logic [23:0]      REJECT_SRC
);

  initial begin
    if (ACK_WAIT < 1 || ACK_WAIT > 3) begin
      $error("ACK_WAIT must be 1 to 3");
    end
  end

  localparam logic [1:0] WAIT_LOAD = 2'(ACK_WAIT);

  ipr_pkg::ipr_regs_t r_reg;
  ipr_pkg::ipr_regs_t r_next;

  // strictly more favoured: smaller value wins
  function automatic logic more_favoured(input logic [7:0] a, input logic [7:0] b);
    more_favoured = a < b;
  endfunction : more_favoured

  // candidate source: routing request, or this processor's queued IPI if its priority is more favoured
  logic        ipi_pending;
  logic        cand_valid;
  logic [23:0] cand_src;
  logic [7:0]  cand_prio;
  logic        is_poll;
  logic        is_ack;

  always_comb begin
    ipi_pending = QUEUED_PRIO != `IPR_PRIO_LEAST;
    cand_valid  = 1'b0;
    cand_src    = `IPR_SRC_NONE;
    cand_prio   = `IPR_PRIO_LEAST;
    if (REQ_VALID && REQ_SRC != `IPR_SRC_NONE) begin
      cand_valid = 1'b1;
      cand_src   = REQ_SRC;
      cand_prio  = REQ_PRIO;
    end
    if (ipi_pending && (!cand_valid || more_favoured(QUEUED_PRIO, cand_prio))) begin
      cand_valid = 1'b1;
      cand_src   = `IPR_SRC_IPI_FIRST;
      cand_prio  = QUEUED_PRIO;
    end
    is_poll = ACC_ADDR == `IPR_OFS_POLL;
    is_ack  = ACC_ADDR == `IPR_OFS_ACK;
  end

  always_comb begin
    r_next           = r_reg;
    r_next.rd_valid  = 1'b0;
    r_next.eoi_valid = 1'b0;
    r_next.reject    = 1'b0;
    case (r_reg.state)
      ipr_pkg::IPR_IDLE: begin
        if (ACC_REQ && !ACC_WRITE) begin
          if (is_ack && ACC_WORD) begin
            r_next.irq      = 1'b0;
            r_next.wait_cnt = WAIT_LOAD;
            r_next.state    = ipr_pkg::IPR_DROP;
          end else begin
            r_next.rd_valid = 1'b1;
            if (is_poll || is_ack) begin
              r_next.rd_data = {r_reg.prio, r_reg.src};
            end else begin
              r_next.rd_data = 32'h00000000;
            end
          end
        end else if (ACC_REQ && ACC_WRITE && is_ack) begin
          if (ACC_WORD) begin
            r_next.eoi_valid = 1'b1;
            r_next.eoi_src   = ACC_WDATA[`IPR_SRC_MSB:0];
          end
          r_next.prio = ACC_WDATA[`IPR_PRIO_MSB:`IPR_PRIO_LSB];
          if (r_reg.src != `IPR_SRC_NONE &&
              !more_favoured(r_reg.src_prio, ACC_WDATA[`IPR_PRIO_MSB:`IPR_PRIO_LSB])) begin
            r_next.reject     = 1'b1;
            r_next.reject_src = r_reg.src;
            r_next.src        = `IPR_SRC_NONE;
            r_next.src_prio   = `IPR_PRIO_LEAST;
            r_next.irq        = 1'b0;
          end
        end else begin
          // stores at the polling address fall through unused
          if (cand_valid && more_favoured(cand_prio, r_reg.prio) &&
              (r_reg.src == `IPR_SRC_NONE || more_favoured(cand_prio, r_reg.src_prio))) begin
            if (r_reg.src != `IPR_SRC_NONE) begin
              r_next.reject     = 1'b1;
              r_next.reject_src = r_reg.src;
            end
            r_next.src      = cand_src;
            r_next.src_prio = cand_prio;
            r_next.irq      = 1'b1;
          end else if (REQ_VALID && REQ_SRC != `IPR_SRC_NONE && REQ_SRC != r_reg.src) begin
            r_next.reject     = 1'b1;
            r_next.reject_src = REQ_SRC;
          end
        end
      end
      ipr_pkg::IPR_DROP: begin
        if (r_reg.wait_cnt <= 2'h1) begin
          r_next.state = ipr_pkg::IPR_REPLY;
        end else begin
          r_next.wait_cnt = r_reg.wait_cnt - 2'h1;
        end
      end
      ipr_pkg::IPR_REPLY: begin
        r_next.rd_valid = 1'b1;
        r_next.rd_data  = {r_reg.prio, r_reg.src};
        if (r_reg.src != `IPR_SRC_NONE) begin
          r_next.prio = r_reg.src_prio;
        end
        r_next.src      = `IPR_SRC_NONE;
        r_next.src_prio = `IPR_PRIO_LEAST;
        r_next.state    = ipr_pkg::IPR_IDLE;
      end
      default: begin
        r_next.state = ipr_pkg::IPR_IDLE;
      end
    endcase
    r_next.req_ready = r_next.state == ipr_pkg::IPR_IDLE && !(ACC_REQ && ACC_WRITE);
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      r_reg.state      <= ipr_pkg::IPR_IDLE;
      r_reg.prio       <= `IPR_PRIO_RESET;
      r_reg.src        <= `IPR_SRC_NONE;
      r_reg.src_prio   <= `IPR_PRIO_LEAST;
      r_reg.wait_cnt   <= 2'h0;
      r_reg.irq        <= 1'b0;
      r_reg.rd_valid   <= 1'b0;
      r_reg.rd_data    <= 32'h00000000;
      r_reg.eoi_valid  <= 1'b0;
      r_reg.eoi_src    <= 24'h000000;
      r_reg.reject     <= 1'b0;
      r_reg.reject_src <= 24'h000000;
      r_reg.req_ready  <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign RD_VALID     = r_reg.rd_valid;
  assign RD_DATA      = r_reg.rd_data;
  assign REQ_READY    = r_reg.req_ready;
  assign IRQ          = r_reg.irq;
  assign EOI_VALID    = r_reg.eoi_valid;
  assign EOI_SRC      = r_reg.eoi_src;
  assign REJECT_VALID = r_reg.reject;
  assign REJECT_SRC   = r_reg.reject_src;

endmodule : ipr_presentation

// ==== testbench/ipr_presentation_properties.sv ====
// assertions on the interrupt request word block
// bound to ipr_presentation, sees its ports only
module ipr_presentation_properties #(
  parameter int ACK_WAIT = 2
) (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        ACC_REQ,
  input wire logic        ACC_WRITE,
  input wire logic [3:0]  ACC_ADDR,
  input wire logic        ACC_WORD,
  input wire logic [31:0] ACC_WDATA,
  input wire logic        RD_VALID,
  input wire logic        REQ_VALID,
  input wire logic [23:0] REQ_SRC,
  input wire logic [7:0]  QUEUED_PRIO,
  input wire logic        REQ_READY,
  input wire logic        IRQ,
  input wire logic        EOI_VALID,
  input wire logic [23:0] EOI_SRC,
  input wire logic        REJECT_VALID,
  input wire logic [23:0] REJECT_SRC
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  wire ld = ACC_REQ && !ACC_WRITE && REQ_READY;
  wire eos = ACC_REQ && ACC_WRITE && ACC_WORD && ACC_ADDR == 4'h4;
  wire offer = REQ_VALID && REQ_SRC != 24'h0 || QUEUED_PRIO != 8'hff;
  property p_poll; ld && (ACC_ADDR == 4'h0 || !ACC_WORD) |=> RD_VALID && $stable(IRQ); endproperty
  a_poll: assert property (p_poll) else $error("poll");
  property p_ack; ld && ACC_ADDR == 4'h4 && ACC_WORD |=> !IRQ[*2] ##ACK_WAIT (RD_VALID && !IRQ); endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_ans; RD_VALID && !$past(ld) |-> !IRQ; endproperty
  a_ans: assert property (p_ans) else $error("ans");
  property p_eoi; eos && REQ_READY |=> EOI_VALID && EOI_SRC == 24'($past(ACC_WDATA)); endproperty
  a_eoi: assert property (p_eoi) else $error("eoi");
  property p_eoi_cause; EOI_VALID |-> $past(eos); endproperty
  a_eoi_cause: assert property (p_eoi_cause) else $error("eoi cause");
  property p_rise; $rose(IRQ) |-> $past(offer); endproperty
  a_rise: assert property (p_rise) else $error("rise");
  property p_rej; REJECT_VALID |-> REJECT_SRC != 24'h0; endproperty
  a_rej: assert property (p_rej) else $error("rej");
  property p_drop; ACC_REQ && ACC_WRITE && !ACC_WORD && ACC_ADDR == 4'h4 && ACC_WDATA[31:24] == 8'h00 && IRQ
    && REQ_READY |=> !IRQ ##[0:1] REJECT_VALID; endproperty
  a_drop: assert property (p_drop) else $error("drop");
endmodule : ipr_presentation_properties
bind ipr_presentation ipr_presentation_properties #(.ACK_WAIT(ACK_WAIT)) ipr_presentation_properties_i (.*);

// ==== testbench/ipr_routing_model.sv ====
// routing layer model, one pending request
// assumes the block's clock and reset
module ipr_routing_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        raise,
  input  wire logic [23:0] src,
  input  wire logic [7:0]  prio,
  input  wire logic        req_ready,
  input  wire logic        reject,
  input  wire logic [23:0] rej_src,
  output logic             req_valid,
  output logic [23:0]      req_src,
  output logic [7:0]       req_prio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] held;
  assign req_src = req_valid ? held : ~held;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {req_valid, held, req_prio} <= {1'b0, 24'h0, 8'hff};
    end else if (raise) begin
      {req_valid, held, req_prio} <= {1'b1, src, prio};
    end else if (reject && rej_src == held) begin
      req_valid <= 1'b1;
    end else if (req_ready) begin
      req_valid <= 1'b0;
    end
  end
endmodule : ipr_routing_model

// ==== testbench/testbench.sv ====
// self-checking bench for ipr_presentation
// assumes the routing model and bound checker
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_SYS = 0, RSTN = 0, ACC_REQ = 0, ACC_WRITE = 0, ACC_WORD = 0, raise = 0;
  logic [3:0]  ACC_ADDR = 4'h0;
  logic [31:0] ACC_WDATA = 32'h0, RD_DATA, rd;
  logic [23:0] REQ_SRC, EOI_SRC, REJECT_SRC, src, s1, s2;
  logic [7:0]  REQ_PRIO, prio, QUEUED_PRIO = 8'hff;
  logic        RD_VALID, REQ_VALID, REQ_READY, IRQ, EOI_VALID, REJECT_VALID;
  logic [24:0] end_of_service_notice, rej;
  int          fail_count = 0, comparisons = 0, seed = 32'h56d1;
  always #10 CLK_SYS = ~CLK_SYS;
  ipr_presentation ipr_presentation_i (.*);
  ipr_routing_model ipr_routing_model_i (.clk(CLK_SYS), .rstn(RSTN), .raise(raise), .src(src), .prio(prio),
    .req_ready(REQ_READY), .reject(REJECT_VALID), .rej_src(REJECT_SRC), .req_valid(REQ_VALID),
    .req_src(REQ_SRC), .req_prio(REQ_PRIO));
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [3:0] a, input logic wd, input logic [31:0] d);
    int n;
    for (n = 0; REQ_VALID && n < 10; n++) @(negedge CLK_SYS);
    {ACC_REQ, ACC_WRITE, ACC_ADDR, ACC_WORD, ACC_WDATA} = {1'b1, w, a, wd, d};
    @(negedge CLK_SYS);
    ACC_REQ = 0;
    end_of_service_notice = {EOI_VALID, EOI_SRC};
    rej = {REJECT_VALID, REJECT_SRC};
    for (n = 0; !w && !RD_VALID && n < 8; n++) @(negedge CLK_SYS);
    rd = RD_DATA;
    @(negedge CLK_SYS);
  endtask : acc
  task offer(input logic [7:0] p);
    src = 24'($random(seed)) | 24'h100000;
    prio = p;
    raise = 1;
    @(negedge CLK_SYS);
    raise = 0;
  endtask : offer
  task wait_irq;
    int n;
    for (n = 0; IRQ !== 1'b1 && n < 12; n++) @(negedge CLK_SYS);
  endtask : wait_irq
  initial begin
    #20us;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (3) @(negedge CLK_SYS);
    RSTN = 1;
    acc(0, 4'h0, 1, 0);
    chk(rd, 32'hff000000);
    acc(1, 4'h0, 0, 32'h0);
    acc(1, 4'h4, 0, 32'h40000000);
    acc(0, 4'h0, 1, 0);
    chk(rd, 32'h40000000);
    offer(8'h20);
    s1 = src;
    wait_irq();
    acc(0, 4'h0, 1, 0);
    chk(rd, {8'h40, s1});
    acc(0, 4'h4, 0, 0);
    chk({rd[31:24], 23'h0, IRQ}, 32'h40000001);
    acc(0, 4'h4, 1, 0);
    chk(rd, {8'h40, s1});
    acc(0, 4'h0, 1, 0);
    chk(rd, 32'h20000000);
    offer(8'h30);
    s2 = src;
    repeat (6) @(negedge CLK_SYS);
    chk(32'(IRQ), 0);
    acc(1, 4'h4, 1, {8'h40, s1});
    chk(32'(end_of_service_notice), {8'h01, s1});
    wait_irq();
    acc(0, 4'h0, 1, 0);
    chk(rd, {8'h40, s2});
    acc(1, 4'h4, 0, 32'h0);
    chk(32'(IRQ), 0);
    chk(32'(rej), {8'h01, s2});
    acc(1, 4'h4, 0, 32'hff000000);
    wait_irq();
    QUEUED_PRIO = 8'h05;
    repeat (4) @(negedge CLK_SYS);
    acc(0, 4'h0, 1, 0);
    chk(rd, 32'hff000002);
    acc(0, 4'h4, 1, 0);
    QUEUED_PRIO = 8'hff;
    acc(0, 4'h4, 1, 0);
    chk(32'(rd[23:0]), 0);
    acc(0, 4'h0, 1, 0);
    chk(rd, 32'h05000000);
    conclude();
  end
endmodule : testbench
